// ---- include/hsw_pkg.sv ----
/*
  Constants shared by the pin control logic of a dual high side switch:
  timing counts, sense select codes, fault bit positions, pin indices.
  Assumes a 250 MHz core clock; the long counts are overridable upward.
*/
package hsw_pkg;
  // Core clock rate in kHz.
  localparam int CLK_KHZ = 250000;
  // Direct input low time before sleep entry.
  localparam int TIN_MS = 250;
  localparam int TIN_CYC = TIN_MS * CLK_KHZ;
  // Watchdog timeout.
  localparam int WDTO_MS = 310;
  localparam int WDTO_CYC = WDTO_MS * CLK_KHZ;
  // Longest gap between external clock edges before it counts as lost.
  localparam int CLKMON_US = 100;
  localparam int CLKMON_CYC = CLKMON_US * CLK_KHZ / 1000;
  // Settling time of the sense output before the strobe goes low.
  localparam int SETTLE_US = 10;
  localparam logic [11:0] SETTLE_CYC = 12'(SETTLE_US * CLK_KHZ / 1000);
  // Width of the long timers.
  localparam int CNT_W = 27;
  // Sense select codes, {bit1, bit0}.
  localparam logic [1:0] SEL_OFF = 2'h0;
  localparam logic [1:0] SEL_CH0 = 2'h1;
  localparam logic [1:0] SEL_CH1 = 2'h2;
  localparam logic [1:0] SEL_TEMP = 2'h3;
  // Fault bit positions.
  localparam int FLT_OC = 0;
  localparam int FLT_OT = 1;
  localparam int FLT_VPWR = 2;
  localparam int FLT_SC = 3;
  localparam int FLT_OPEN_LOAD_ON_FAULT = 4;
  localparam int FLT_OPEN_LOAD_OFF_FAULT = 5;
  localparam int FLT_OV = 6;
  localparam int FLT_UV = 7;
  localparam int FLT_CLK = 8;
  localparam int FLT_N = 9;
  localparam logic [FLT_N-1:0] FLT_RESET = 9'h000;
  // Indices of the pins in the synchroniser vector.
  localparam int PIN_DIR0 = 0;
  localparam int PIN_DIR1 = 1;
  localparam int PIN_RST = 2;
  localparam int PIN_PRF0 = 3;
  localparam int PIN_PRF1 = 4;
  localparam int PIN_XCLK = 5;
  localparam int PIN_W = 6;
  // Reset value of the pin synchroniser: profile pins idle high.
  localparam logic [PIN_W-1:0] PIN_RESET = 6'h18;
  // PWM counter width; the period is 256 external clock edges.
  localparam int PWM_W = 8;
  // Operating modes.
  typedef enum logic [1:0] {
    MODE_SLEEP,
    MODE_NORMAL,
    MODE_FAILSAFE
  } hsw_mode_e;
endpackage

// ---- verilog/hsw_sync2.sv ----
/*
  Two flip-flop synchroniser for a vector of pin levels.
  Assumes the pins are quasi-static compared to the core clock.
*/
`timescale 1ns/1ns
module hsw_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta;

  // The first stage is read only by the second stage.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta <= RST_VAL;
      sync_o <= RST_VAL;
    end else if (clk_en_i) begin
      meta <= pin_i;
      sync_o <= meta;
    end
  end
endmodule

// ---- verilog/hsw_pin_ctrl.sv ----
/*
  Pin control logic of a dual high side switch: modes, direct inputs,
  watchdog, external PWM clock, fault flag and sense routing and strobe.
  Assumes the serial word decoder and the analog monitors run on the
  core clock; pins arrive asynchronously and are synchronised here.
*/
`timescale 1ns/1ns
module hsw_pin_ctrl #(
  parameter logic [26:0] TIN_CYC = 27'(hsw_pkg::TIN_CYC),
  parameter logic [26:0] WDTO_CYC = 27'(hsw_pkg::WDTO_CYC),
  parameter logic [26:0] CLKMON_CYC = 27'(hsw_pkg::CLKMON_CYC)
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic [1:0] direct_in_i,
  input wire logic reset_wake_n_i,
  input wire logic [1:0] load_profile_inputs_i,
  input wire logic ext_pwm_clk_i,
  input wire logic sense_select_bit0_i,
  input wire logic sense_select_bit1_i,
  input wire logic track_hold_en_i,
  input wire logic vdd_present_i,
  input wire logic [1:0] oc_window_i,
  input wire logic spi_word_valid_i,
  input wire logic watchdog_toggle_bit_i,
  input wire logic watchdog_disable_bit_i,
  input wire logic [1:0] pwm_en_i,
  input wire logic [7:0] pwm_duty0_i,
  input wire logic [7:0] pwm_duty1_i,
  input wire logic [7:0] pwm_delay0_i,
  input wire logic [7:0] pwm_delay1_i,
  input wire logic [7:0] fault_event_i,
  input wire logic [8:0] fault_read_clr_i,
  output logic [1:0] ch_on_o,
  output logic awake_o,
  output logic failsafe_o,
  output logic regs_reset_o,
  output logic [1:0] motor_profile_o,
  output logic [1:0] sense_route_o,
  output logic sense_oe_n_o,
  output logic sense_hold_o,
  output logic sense_ready_o,
  output logic sense_ready_oe_n_o,
  output logic fault_flag_o,
  output logic fault_flag_oe_n_o,
  output logic [8:0] fault_status_o
);
  logic [hsw_pkg::PIN_W-1:0] pins_s;
  logic [1:0] dir_q;
  logic rst_q;
  logic xclk_q;
  hsw_pkg::hsw_mode_e mode;
  hsw_pkg::hsw_mode_e next_mode;
  logic [26:0] low_cnt;
  logic [26:0] wd_cnt;
  logic [26:0] xmon_cnt;
  logic wd_armed;
  logic wd_seen;
  logic wd_last;
  logic [7:0] pwm_cnt;
  logic [11:0] settle_cnt;
  logic [1:0] next_ch_on;
  logic [8:0] next_flt;
  logic od_low;

  // Pin synchronisers.
  hsw_sync2 #(
    .W(hsw_pkg::PIN_W),
    .RST_VAL(hsw_pkg::PIN_RESET)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .pin_i({ext_pwm_clk_i, load_profile_inputs_i, reset_wake_n_i,
      direct_in_i}),
    .sync_o(pins_s)
  );

  // Decoded pin levels and edges.
  wire [1:0] dir = pins_s[hsw_pkg::PIN_DIR1:hsw_pkg::PIN_DIR0];
  wire rst_lvl = pins_s[hsw_pkg::PIN_RST];
  wire xclk = pins_s[hsw_pkg::PIN_XCLK];
  wire [1:0] dir_rise = dir & ~dir_q;
  wire rst_rise = rst_lvl & ~rst_q;
  wire xclk_rise = xclk & ~xclk_q;
  wire in_sleep = (mode == hsw_pkg::MODE_SLEEP);
  wire in_normal = (mode == hsw_pkg::MODE_NORMAL);
  wire in_fs = (mode == hsw_pkg::MODE_FAILSAFE);

  // Low-time timer toward sleep while the reset input is low.
  wire low_run = !rst_lvl && (dir == 2'h0) && !in_sleep;
  wire low_done = low_run && (low_cnt == TIN_CYC - 27'h1);

  // Watchdog on the toggle bit of every serial word after release.
  wire wd_run = in_normal && wd_armed && !watchdog_disable_bit_i;
  wire wd_kick = spi_word_valid_i && wd_armed &&
    (!wd_seen || (watchdog_toggle_bit_i != wd_last));
  wire wd_expired = wd_run && (wd_cnt == WDTO_CYC - 27'h1);

  // The PWM enables are forced off while reset is low; other configuration inputs pass through.
  wire [1:0] pwm_act = pwm_en_i & {2{rst_lvl}};
  wire [1:0][7:0] duty = {pwm_duty1_i, pwm_duty0_i};
  wire [1:0][7:0] delay = {pwm_delay1_i, pwm_delay0_i};
  logic [1:0] pwm_on;

  // PWM phase per channel: delay shifts turn-on, duty sets on-time.
  for (genvar c = 0; c < 2; c++) begin : g_pwm
    wire [7:0] phase = pwm_cnt - delay[c];
    assign pwm_on[c] = (phase < duty[c]);
  end

  // External clock supervision while a channel depends on it.
  wire xmon_run = in_normal && (pwm_act != 2'h0);
  wire clk_fail = xmon_run && (xmon_cnt == CLKMON_CYC - 27'h1);

  // Sticky fault bits: a new event wins over a read clear.
  wire [8:0] flt_set = {clk_fail, fault_event_i};
  assign next_flt = (fault_status_o & ~fault_read_clr_i) | flt_set;

  // Sense routing and availability.
  wire [1:0] sel = {sense_select_bit1_i, sense_select_bit0_i};
  wire sel_ch = (sel == hsw_pkg::SEL_CH0) || (sel == hsw_pkg::SEL_CH1);
  wire sel_temp = (sel == hsw_pkg::SEL_TEMP);
  wire src_on = next_ch_on[sel[1]];
  wire sense_avail = in_normal && vdd_present_i && (oc_window_i == 2'h0)
    && (sel != hsw_pkg::SEL_OFF);
  wire next_hold = sense_avail && track_hold_en_i && sel_ch && !src_on;
  wire src_live = sel_temp || src_on || next_hold;
  wire off_evt = (ch_on_o & ~next_ch_on) != 2'h0;
  wire settled = (settle_cnt == hsw_pkg::SETTLE_CYC - 12'h001);
  wire next_sync_low = sense_avail && src_live && !off_evt && settled;

  // Mode sequencing between sleep, normal and fail-safe.
  always_comb begin
    next_mode = mode;
    case (mode)
      hsw_pkg::MODE_SLEEP: begin
        if ((dir_rise != 2'h0) || rst_rise) begin
          next_mode = hsw_pkg::MODE_NORMAL;
        end
      end
      hsw_pkg::MODE_NORMAL: begin
        if (wd_expired) begin
          next_mode = hsw_pkg::MODE_FAILSAFE;
        end else if (low_done) begin
          next_mode = hsw_pkg::MODE_SLEEP;
        end
      end
      hsw_pkg::MODE_FAILSAFE: begin
        if (low_done) begin
          next_mode = hsw_pkg::MODE_SLEEP;
        end else if (rst_rise) begin
          next_mode = hsw_pkg::MODE_NORMAL;
        end
      end
      default: begin
        next_mode = hsw_pkg::MODE_SLEEP;
      end
    endcase
  end

  // Channel drive: direct inputs, or the PWM when it owns the channel.
  always_comb begin
    next_ch_on = 2'h0;
    case (mode)
      hsw_pkg::MODE_NORMAL: begin
        next_ch_on = (pwm_act & pwm_on) | (~pwm_act & dir);
      end
      hsw_pkg::MODE_FAILSAFE: begin
        next_ch_on = dir;
      end
      default: begin
        next_ch_on = 2'h0;
      end
    endcase
  end

  // Edge detectors and mode register.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dir_q <= 2'h0;
      rst_q <= 1'b0;
      xclk_q <= 1'b0;
      mode <= hsw_pkg::MODE_SLEEP;
    end else if (clk_en_i) begin
      dir_q <= dir;
      rst_q <= rst_lvl;
      xclk_q <= xclk;
      mode <= next_mode;
    end
  end

  // Low-time counter; restarts on any direct input activity.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      low_cnt <= 27'h0000000;
    end else if (clk_en_i) begin
      if (!low_run) begin
        low_cnt <= 27'h0000000;
      end else if (!low_done) begin
        low_cnt <= low_cnt + 27'h0000001;
      end
    end
  end

  // Watchdog arming, toggle memory and timer.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wd_armed <= 1'b0;
      wd_seen <= 1'b0;
      wd_last <= 1'b0;
      wd_cnt <= 27'h0000000;
    end else if (clk_en_i) begin
      wd_armed <= rst_lvl && (wd_armed || rst_rise);
      if (rst_rise) begin
        wd_seen <= 1'b0;
      end else if (spi_word_valid_i && wd_armed) begin
        wd_seen <= 1'b1;
        wd_last <= watchdog_toggle_bit_i;
      end
      if (rst_rise || !wd_run || wd_kick) begin
        wd_cnt <= 27'h0000000;
      end else begin
        wd_cnt <= wd_cnt + 27'h0000001;
      end
    end
  end

  // PWM period counter on external edges, and clock loss timer restarted by them.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pwm_cnt <= 8'h00;
      xmon_cnt <= 27'h0000000;
    end else if (clk_en_i) begin
      if (xclk_rise) begin
        pwm_cnt <= pwm_cnt + 8'h01;
      end
      if (xclk_rise || !xmon_run) begin
        xmon_cnt <= 27'h0000000;
      end else if (!clk_fail) begin
        xmon_cnt <= xmon_cnt + 27'h0000001;
      end
    end
  end

  // Sense settling counter, restarted at every turn-off.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      settle_cnt <= 12'h000;
    end else if (clk_en_i) begin
      if (off_evt || !sense_avail || !src_live) begin
        settle_cnt <= 12'h000;
      end else if (!settled) begin
        settle_cnt <= settle_cnt + 12'h001;
      end
    end
  end

  // Channel, mode and profile outputs.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ch_on_o <= 2'h0;
      awake_o <= 1'b0;
      failsafe_o <= 1'b0;
      regs_reset_o <= 1'b1;
      motor_profile_o <= 2'h3;
    end else if (clk_en_i) begin
      ch_on_o <= next_ch_on;
      awake_o <= (next_mode != hsw_pkg::MODE_SLEEP);
      failsafe_o <= (next_mode == hsw_pkg::MODE_FAILSAFE);
      regs_reset_o <= !rst_lvl;
      motor_profile_o <= pins_s[hsw_pkg::PIN_PRF1:hsw_pkg::PIN_PRF0];
    end
  end

  // Sense outputs and open-drain pins; open-drain data is always low.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sense_route_o <= hsw_pkg::SEL_OFF;
      sense_oe_n_o <= 1'b1;
      sense_hold_o <= 1'b0;
      sense_ready_oe_n_o <= 1'b1;
      od_low <= 1'b0;
    end else if (clk_en_i) begin
      sense_route_o <= sel;
      sense_oe_n_o <= !sense_avail;
      sense_hold_o <= next_hold;
      sense_ready_oe_n_o <= !next_sync_low;
      od_low <= 1'b0;
    end
  end

  assign sense_ready_o = od_low;
  assign fault_flag_o = od_low;

  // Fault status register and fault flag.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fault_status_o <= hsw_pkg::FLT_RESET;
      fault_flag_oe_n_o <= 1'b1;
    end else if (clk_en_i) begin
      fault_status_o <= next_flt;
      fault_flag_oe_n_o <= (next_flt == 9'h000);
    end
  end

  // Checks on the behaviour above.
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i || !clk_en_i);

  sequence s_wd_expire;
    wd_expired;
  endsequence
  sequence s_in_failsafe;
    ##1 failsafe_o ##1 (mode == hsw_pkg::MODE_FAILSAFE);
  endsequence

  AST_SENSE_OFF: assert property (
    (sel == hsw_pkg::SEL_OFF) |=> sense_oe_n_o)
    else $error("sense driven with select off");
  AST_HOLD_OFF: assert property (
    sense_hold_o |-> !ch_on_o[sense_route_o[1]])
    else $error("hold while channel on");
  AST_OC_BLANK: assert property (
    (oc_window_i != 2'h0) |=> sense_oe_n_o)
    else $error("sense during overcurrent window");
  AST_FS_NOSENSE: assert property (
    (in_fs || !vdd_present_i) |=> sense_oe_n_o)
    else $error("sense in failsafe or without supply");
  AST_SYNC_VALID: assert property (
    !sense_ready_oe_n_o |-> !sense_oe_n_o)
    else $error("strobe low without sense");
  AST_SYNC_RISE: assert property (
    off_evt |=> sense_ready_oe_n_o &&
      (($past(ch_on_o) & ~ch_on_o) != 2'h0))
    else $error("no strobe rise at turn-off");
  AST_OD_LOW: assert property (!sense_ready_o && !fault_flag_o)
    else $error("open drain driven high");
  AST_DIRECT: assert property (
    in_normal && (pwm_act == 2'h0) |=> ch_on_o == $past(dir))
    else $error("direct input not followed");
  AST_WAKE: assert property (
    in_sleep && (dir_rise != 2'h0) |=> awake_o ##1 in_normal)
    else $error("no wake on direct input");
  AST_FAULT_FLAG: assert property (
    (fault_event_i != 8'h00) |=> !fault_flag_oe_n_o)
    else $error("fault flag not pulled");
  AST_READ_CLEAR: assert property (
    ((fault_status_o & fault_read_clr_i & ~flt_set) != 9'h000) |=>
      ((fault_status_o & $past(fault_read_clr_i & ~flt_set)) == 9'h000))
    else $error("read did not clear fault");
  AST_SLEEP_STAY: assert property (
    in_sleep && !rst_lvl && (dir_rise == 2'h0) |=> in_sleep)
    else $error("left sleep without wake");
  AST_WD_FS: assert property (s_wd_expire |-> s_in_failsafe)
    else $error("watchdog expiry without failsafe");
  AST_WATCHDOG_DISABLE_BIT: assert property (
    in_normal && watchdog_disable_bit_i |=> !failsafe_o)
    else $error("failsafe with watchdog disabled");
  AST_LOW_SLEEP: assert property (low_done |=> !awake_o ##1 in_sleep)
    else $error("no sleep after low time");
endmodule

// ---- verification/hsw_host_model.sv ----
/*
  Host side model: sends serial words whose watchdog bit alternates, and
  pulls up the two open-drain flag wires of the switch.
  Assumes one switch on each flag wire and the core clock of the block.
*/
`timescale 1ns/1ns
module hsw_host_model #(
  parameter int GAP = 20
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic wd_run_i,
  input wire logic sense_ready_oe_n_i,
  input wire logic fault_flag_oe_n_i,
  output logic spi_word_valid_o,
  output logic watchdog_toggle_bit_o,
  output logic sense_ready_line_o,
  output logic fault_flag_line_o
);
  logic [7:0] gap_cnt;
  logic tgl;
  // The pull-ups give the high level; the switch can only pull low.
  assign sense_ready_line_o = sense_ready_oe_n_i;
  assign fault_flag_line_o = fault_flag_oe_n_i;
  // Between words the toggle bit shows junk, so only the pulse qualifies it.
  assign watchdog_toggle_bit_o = spi_word_valid_o ? tgl : ~tgl;
  // One word every GAP cycles, the toggle bit inverted on each word.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      gap_cnt <= 8'h00;
      spi_word_valid_o <= 1'b0;
      tgl <= 1'b0;
    end else begin
      spi_word_valid_o <= wd_run_i && (gap_cnt == 8'(GAP - 1));
      gap_cnt <= (gap_cnt == 8'(GAP - 1)) ? 8'h00 : gap_cnt + 8'h01;
      if (spi_word_valid_o) begin
        tgl <= ~tgl;
      end
    end
  end
endmodule

// ---- verification/hsw_pin_ctrl_tb.sv ----
/*
  Self-checking bench of the pin control logic: sleep test, table of routing
  cases, then watchdog, fault, clock loss and strobe tests.
  Assumes the host model drives the serial word strobe and pull-ups.
*/
`timescale 1ns/1ns
module hsw_pin_ctrl_tb;
  localparam int TIN = 64;
  localparam int WDTO = 80;
  typedef struct packed {
    logic [1:0] dir;
    logic [1:0] prf;
    logic [1:0] sel;
    logic vdd;
    logic [1:0] oc;
    logic [1:0] ch;
    logic [1:0] mot;
    logic oen;
  } hsw_row_s;
  hsw_row_s rows [7] = '{
    '{2'h1, 2'h0, 2'h1, 1'h1, 2'h0, 2'h1, 2'h0, 1'h0},
    '{2'h2, 2'h1, 2'h2, 1'h1, 2'h0, 2'h2, 2'h1, 1'h0},
    '{2'h3, 2'h2, 2'h3, 1'h1, 2'h0, 2'h3, 2'h2, 1'h0},
    '{2'h0, 2'h3, 2'h0, 1'h1, 2'h0, 2'h0, 2'h3, 1'h1},
    '{2'h1, 2'h3, 2'h1, 1'h1, 2'h1, 2'h1, 2'h3, 1'h1},
    '{2'h1, 2'h3, 2'h3, 1'h1, 2'h2, 2'h1, 2'h3, 1'h1},
    '{2'h2, 2'h3, 2'h2, 1'h0, 2'h0, 2'h2, 2'h3, 1'h1}};
  logic core_clk_i, reset_i, rst_n, th, vdd, watchdog_disable_bit, xclk, xclk_run;
  logic clk_en, sr_dat, ff_dat;
  logic wd_run, word_v, wd_bit, sr_oe_n, ff_oe_n, sr_line, ff_line;
  logic awake_o, failsafe_o, regs_reset_o, sense_oe_n_o, sense_hold_o;
  logic [1:0] dir, prf, sel, oc, pwm_en, ch_on_o, motor_profile_o;
  logic [1:0] sense_route_o;
  logic [2:0] xdiv;
  logic [7:0] duty1, evt;
  logic [8:0] clr, fault_status_o;
  int n_fail, samples_checked;

  hsw_pin_ctrl #(
    .TIN_CYC(27'(TIN)),
    .WDTO_CYC(27'(WDTO)),
    .CLKMON_CYC(27'h28)
  ) hsw_pin_ctrl_i (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .clk_en_i(clk_en),
    .direct_in_i(dir), .reset_wake_n_i(rst_n),
    .load_profile_inputs_i(prf), .ext_pwm_clk_i(xclk),
    .sense_select_bit0_i(sel[0]), .sense_select_bit1_i(sel[1]),
    .track_hold_en_i(th), .vdd_present_i(vdd), .oc_window_i(oc),
    .spi_word_valid_i(word_v), .watchdog_toggle_bit_i(wd_bit),
    .watchdog_disable_bit_i(watchdog_disable_bit), .pwm_en_i(pwm_en),
    .pwm_duty0_i(8'h00), .pwm_duty1_i(duty1), .pwm_delay0_i(8'h00),
    .pwm_delay1_i(8'h00), .fault_event_i(evt), .fault_read_clr_i(clr),
    .ch_on_o(ch_on_o), .awake_o(awake_o), .failsafe_o(failsafe_o),
    .regs_reset_o(regs_reset_o), .motor_profile_o(motor_profile_o),
    .sense_route_o(sense_route_o), .sense_oe_n_o(sense_oe_n_o),
    .sense_hold_o(sense_hold_o), .sense_ready_o(sr_dat),
    .sense_ready_oe_n_o(sr_oe_n), .fault_flag_o(ff_dat),
    .fault_flag_oe_n_o(ff_oe_n), .fault_status_o(fault_status_o));

  hsw_host_model #(.GAP(20)) hsw_host_model_i (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .wd_run_i(wd_run),
    .sense_ready_oe_n_i(sr_oe_n), .fault_flag_oe_n_i(ff_oe_n),
    .spi_word_valid_o(word_v), .watchdog_toggle_bit_o(wd_bit),
    .sense_ready_line_o(sr_line), .fault_flag_line_o(ff_line));

  // Clock of 4 ns and an external PWM clock of eight core cycles.
  always #2 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    if (xclk_run) begin
      xdiv <= xdiv + 3'h1;
      xclk <= xdiv[2];
    end
  end

  // Compares one value and counts it; a mismatch is printed at once.
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Cuts a hang short well beyond the expected length of the run.
  initial begin
    step(20000);
    n_fail++;
    wrap_up;
  end

  // Main sequence.
  initial begin
    core_clk_i = 0; reset_i = 1; rst_n = 0; dir = 0; prf = 2'h3; sel = 0;
    th = 0; vdd = 1; oc = 0; watchdog_disable_bit = 0; wd_run = 0; pwm_en = 0;
    duty1 = 0; evt = 0; clr = 0; xclk = 0; xclk_run = 0; xdiv = 0;
    n_fail = 0; samples_checked = 0;
    clk_en = 1;
    step(6);
    reset_i <= 1'b0;
    step(4);
    check(regs_reset_o, 9'h001);
    check(motor_profile_o, 9'h003);
    check(awake_o, 9'h000);
    check(sense_oe_n_o, 9'h001);
    check(ff_line, 9'h001);
    // Wake by a direct input, then fall asleep after the low time.
    dir <= 2'h1;
    step(5);
    check(awake_o, 9'h001);
    check(ch_on_o, 9'h001);
    dir <= 2'h0;
    step(TIN - 8);
    check(awake_o, 9'h001);
    step(16);
    check(awake_o, 9'h000);
    // Wake by the reset pin with the host feeding the watchdog.
    wd_run <= 1'b1;
    rst_n <= 1'b1;
    step(5);
    check(awake_o, 9'h001);
    check(regs_reset_o, 9'h000);
    foreach (rows[i]) begin
      dir <= rows[i].dir;
      prf <= rows[i].prf;
      sel <= rows[i].sel;
      vdd <= rows[i].vdd;
      oc <= rows[i].oc;
      step(5);
      check(ch_on_o, rows[i].ch);
      check(motor_profile_o, rows[i].mot);
      check(sense_route_o, rows[i].sel);
      check(sense_oe_n_o, rows[i].oen);
      check(failsafe_o, 9'h000);
    end
    // Host goes quiet: fail-safe after the timeout, sensing off.
    sel <= 2'h3;
    vdd <= 1'b1;
    wd_run <= 1'b0;
    step(50);
    check(failsafe_o, 9'h000);
    step(50);
    check(failsafe_o, 9'h001);
    check(sense_oe_n_o, 9'h001);
    // Reset pin pulse leaves fail-safe; with the disable bit no timeout.
    rst_n <= 1'b0;
    step(3);
    rst_n <= 1'b1;
    watchdog_disable_bit <= 1'b1;
    step(150);
    check(failsafe_o, 9'h000);
    // Each of the eight fault event types sets its own bit and the flag; a read clears it.
    for (int i = 0; i < 8; i++) begin
      evt <= 8'h01 << i;
      step(1);
      evt <= 8'h00;
      step(2);
      check(fault_status_o, 9'h001 << i);
      check(ff_line, 9'h000);
      clr <= 9'h001 << i;
      step(1);
      clr <= 9'h000;
      step(2);
      check(fault_status_o, 9'h000);
      check(ff_line, 9'h001);
    end
    // A new event wins over a clear in the same cycle.
    evt <= 8'h01;
    clr <= 9'h001;
    step(1);
    evt <= 8'h00;
    clr <= 9'h000;
    step(2);
    check(fault_status_o, 9'h001);
    clr <= 9'h001;
    step(1);
    clr <= 9'h000;
    // PWM with zero on-time keeps channel 1 off; then the clock stops.
    pwm_en <= 2'h2;
    dir <= 2'h3;
    xclk_run <= 1'b1;
    step(600);
    check(ch_on_o, 9'h001);
    check(fault_status_o[8], 9'h000);
    xclk_run <= 1'b0;
    step(60);
    check(fault_status_o[8], 9'h001);
    check(ff_line, 9'h000);
    xclk_run <= 1'b1;
    step(16);
    clr <= 9'h100;
    step(1);
    clr <= 9'h000;
    step(2);
    check(fault_status_o[8], 9'h000);
    // Strobe falls once settled and rises at the turn-off instant.
    pwm_en <= 2'h0;
    th <= 1'b1;
    sel <= 2'h1;
    dir <= 2'h1;
    step(2520);
    check(sr_line, 9'h000);
    dir <= 2'h0;
    step(5);
    check(ch_on_o, 9'h000);
    check(sr_line, 9'h001);
    check(sense_hold_o, 9'h001);
    check(sense_oe_n_o, 9'h000);
    check(sr_dat, 9'h000);
    check(ff_dat, 9'h000);
    // Clock enable low freezes the synchronisers and the channel outputs.
    clk_en <= 1'b0;
    dir <= 2'h1;
    step(6);
    check(ch_on_o, 9'h000);
    clk_en <= 1'b1;
    step(5);
    check(ch_on_o, 9'h001);
    wrap_up;
  end
endmodule
